// File: src/rgc_pkg.sv
// Constants and carrier types for the receive gain and regulator control bank.
// Assumes one core clock; host accesses arrive already decoded from the pins.
package rgc_pkg;

    // Register addresses on the host interface
    localparam logic [4:0] ADDR_ISO_CTRL = 5'h01;
    localparam logic [4:0] ADDR_RX_SET = 5'h0a;
    localparam logic [4:0] ADDR_REG_CTRL = 5'h0b;

    // Values after reset or enable low
    localparam logic [7:0] RX_SET_RST = 8'h40;
    localparam logic [7:0] REG_CTRL_RST = 8'h87;
    // Bits 4 and 3 of the regulator register hold no state
    localparam logic [7:0] REG_CTRL_WMASK = 8'he7;

    // Field positions, receive register
    localparam int RX_B_BAND110 = 7;
    localparam int RX_B_BAND200 = 6;
    localparam int RX_B_BAND450 = 5;
    localparam int RX_B_HBT = 4;
    localparam int RX_B_GAIN_HI = 3;
    localparam int RX_B_GAIN_LO = 2;
    localparam int RX_B_AGC_THR = 1;
    localparam int RX_B_NO_LIM = 0;

    // Field positions, regulator register
    localparam int RG_B_AUTO = 7;
    localparam int RG_B_EXT_AMP = 6;
    localparam int RG_B_IO_LOW = 5;

    // Gain reduction in dB
    localparam logic [5:0] GR_DB_STEP = 6'h05;
    localparam logic [5:0] GR_DB_HBT = 6'h12;

    // AGC activation multiples of the digitizing threshold
    localparam logic [2:0] AGC_MULT_LOW = 3'h3;
    localparam logic [2:0] AGC_MULT_DEF = 3'h5;

    // AGC step counts and pulse limit
    localparam logic [2:0] AGC_COMP_STEPS = 3'h4;
    localparam logic [1:0] AGC_GAIN_STEPS = 2'h3;
    localparam logic [3:0] AGC_LIM_PULSES = 4'h8;

    // Supplies in units of 0.1 V
    localparam logic [7:0] V_RF5_BASE = 8'h2b;
    localparam logic [7:0] V_3V_BASE = 8'h1b;
    localparam logic [7:0] V_A5_FIXED = 8'h23;
    localparam logic [7:0] V_X_CAP = 8'h22;

    // Regulator headroom in mV for automatic mode
    localparam logic [8:0] HR_MV_250 = 9'h0fa;
    localparam logic [8:0] HR_MV_350 = 9'h15e;
    localparam logic [8:0] HR_MV_400 = 9'h190;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [7:0] wdata;
    } rgc_host_req_s;

    typedef struct packed {
        logic band_110k_570k_select;
        logic band_200k_900k_select;
        logic band_450k_1500k_select;
        logic band_100k_1500k_hbt;
        logic band_240k_1400k_default;
    } rgc_band_s;

    typedef enum {AGC_OFF, AGC_ARMED, AGC_FROZEN} rgc_agc_e;

endpackage

// File: src/rgc_ctrl.sv
// Receive filter/gain register, regulator/IO register and AGC sequencer.
// Assumes host strobes are single-cycle and synchronous to core_clk_i.
// Overview of operation
// - RX register presets 0x40 on reset, ISO write
// - All band bits zero selects 240k-1.4M band
// - Each band bit selects its own band
// - Two-bit field gives 0/5/10/15 dB reduction
// - Threshold bit picks 3x, else 5x
// - AGC runs only while enable input set
// - AGC reduces gain above chosen threshold
// - Four comparator steps, then three gain steps
// - AGC armed when transmission finishes
// - Without unlimit bit, AGC freezes after 8 pulses
// - Preset per standard, host may override after
// - Regulator register presets 0x87 on reset
// - External amplifier disables peak detectors
// - Regulator bits 4 and 3 read zero
// - Manual 5V: RF 4.3-5.0V, A 3.5, X 3.4
// - Manual 3V: all supplies 2.7-3.4V
// - Auto headroom 250/350/400 mV by bits
`timescale 1ns/1ns
`default_nettype none

module rgc_ctrl (
    input wire logic core_clk_i, // 20 MHz core clock
    input wire logic rst_i, // Power-on reset, async high
    input wire logic en_i, // Chip enable, low presets
    input wire rgc_pkg::rgc_host_req_s host_req_i, // Host access
    output logic [7:0] rdata_o, // Read data
    output logic rdata_valid_o, // Read data valid pulse
    input wire logic five_volt_sys_i, // 5-V system selected
    input wire logic agc_enable_i, // AGC enable from status ctrl
    input wire logic tx_done_i, // Transmission finished pulse
    input wire logic rx_active_i, // Reception in progress
    input wire logic subcarrier_pulse_i, // One subcarrier pulse
    input wire logic lvl_over_3x_i, // Level above 3x threshold
    input wire logic lvl_over_5x_i, // Level above 5x threshold
    output var rgc_pkg::rgc_band_s band_o, // Band-pass select
    output logic [5:0] gain_reduce_db_o, // Total fixed reduction
    output logic [2:0] agc_level_mult_o, // AGC activation multiple
    output logic [2:0] comp_adj_step_o, // Comparator steps taken
    output logic [1:0] agc_gain_step_o, // Gain steps taken
    output logic agc_frozen_o, // AGC blocked for packet
    output logic auto_reg_o, // Automatic regulation
    output logic [8:0] headroom_mv_o, // Auto headroom in mV
    output logic [7:0] vdd_rf_dv_o, // RF supply, 0.1 V units
    output logic [7:0] vdd_a_dv_o, // Analog supply, 0.1 V units
    output logic [7:0] vdd_x_dv_o, // Digital supply, 0.1 V units
    output logic peak_det_off_o, // Internal peak detectors off
    output logic mod_pin_output_o, // Modulation pin drives out
    output logic io_low_drive_o // Low-voltage IO drive
);

    logic [7:0] rx_set_q;
    logic [7:0] reg_ctrl_q;
    logic [7:0] rdata_q;
    logic rdata_valid_q;
    logic wr_iso, wr_rx, wr_reg;
    rgc_pkg::rgc_band_s band_q;
    logic [5:0] gain_db_q;
    logic [5:0] gain_field_db;
    logic [2:0] mult_q;
    rgc_pkg::rgc_agc_e agc_state_q;
    logic [3:0] pulse_cnt_q;
    logic [2:0] comp_q;
    logic [1:0] gain_q;
    logic agc_hit;
    logic agc_run;
    logic freeze_now;
    logic auto_q, peak_off_q, io_low_q;
    logic [8:0] hr_q;
    logic [7:0] vrf_q, va_q, vx_q;
    logic [7:0] vcode;

    assign wr_iso = host_req_i.wr && host_req_i.addr == rgc_pkg::ADDR_ISO_CTRL;
    assign wr_rx = host_req_i.wr && host_req_i.addr == rgc_pkg::ADDR_RX_SET;
    assign wr_reg = host_req_i.wr
        && host_req_i.addr == rgc_pkg::ADDR_REG_CTRL;

    // Protocol write presets; a same-cycle direct write cannot occur
    // because both share one address bus.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_set_q <= rgc_pkg::RX_SET_RST;
        end else if (!en_i || wr_iso) begin
            rx_set_q <= rgc_pkg::RX_SET_RST;
        end else if (wr_rx) begin
            rx_set_q <= host_req_i.wdata;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_ctrl_q <= rgc_pkg::REG_CTRL_RST;
        end else if (!en_i) begin
            reg_ctrl_q <= rgc_pkg::REG_CTRL_RST;
        end else if (wr_reg) begin
            // Unused bits never store
            reg_ctrl_q <= host_req_i.wdata & rgc_pkg::REG_CTRL_WMASK;
        end
    end

    // Read port: one cycle latency, unmapped addresses read zero
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 8'h00;
            rdata_valid_q <= 1'b0;
        end else begin
            rdata_valid_q <= host_req_i.rd;
            if (host_req_i.rd) begin
                unique case (host_req_i.addr)
                    rgc_pkg::ADDR_RX_SET: rdata_q <= rx_set_q;
                    rgc_pkg::ADDR_REG_CTRL: rdata_q <= reg_ctrl_q;
                    default: rdata_q <= 8'h00;
                endcase
            end
        end
    end

    // Filter and fixed gain decode
    always_comb begin
        unique case ({rx_set_q[rgc_pkg::RX_B_GAIN_HI],
                      rx_set_q[rgc_pkg::RX_B_GAIN_LO]})
            2'b00: gain_field_db = 6'h00;
            2'b01: gain_field_db = rgc_pkg::GR_DB_STEP;
            2'b10: gain_field_db = 6'(2 * rgc_pkg::GR_DB_STEP);
            2'b11: gain_field_db = 6'(3 * rgc_pkg::GR_DB_STEP);
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            band_q <= '0;
            gain_db_q <= 6'h00;
            mult_q <= rgc_pkg::AGC_MULT_DEF;
        end else begin
            band_q.band_110k_570k_select <=
                rx_set_q[rgc_pkg::RX_B_BAND110];
            band_q.band_200k_900k_select <=
                rx_set_q[rgc_pkg::RX_B_BAND200];
            band_q.band_450k_1500k_select <=
                rx_set_q[rgc_pkg::RX_B_BAND450];
            band_q.band_100k_1500k_hbt <=
                rx_set_q[rgc_pkg::RX_B_HBT];
            band_q.band_240k_1400k_default <=
                rx_set_q[7:4] == 4'h0;
            gain_db_q <= gain_field_db
                + (rx_set_q[rgc_pkg::RX_B_HBT] ? rgc_pkg::GR_DB_HBT
                                               : 6'h00);
            mult_q <= rx_set_q[rgc_pkg::RX_B_AGC_THR]
                ? rgc_pkg::AGC_MULT_LOW : rgc_pkg::AGC_MULT_DEF;
        end
    end

    // AGC sequencer
    assign agc_hit = rx_set_q[rgc_pkg::RX_B_AGC_THR]
        ? lvl_over_3x_i : lvl_over_5x_i;
    assign agc_run = agc_state_q == rgc_pkg::AGC_ARMED && rx_active_i
        && !tx_done_i;
    // Freeze on the eighth pulse unless unlimited
    assign freeze_now = agc_run && subcarrier_pulse_i
        && !rx_set_q[rgc_pkg::RX_B_NO_LIM]
        && pulse_cnt_q == rgc_pkg::AGC_LIM_PULSES - 4'h1;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            agc_state_q <= rgc_pkg::AGC_OFF;
        end else if (!en_i || !agc_enable_i) begin
            agc_state_q <= rgc_pkg::AGC_OFF;
        end else begin
            unique case (agc_state_q)
                rgc_pkg::AGC_OFF: begin
                    if (tx_done_i) begin
                        agc_state_q <= rgc_pkg::AGC_ARMED;
                    end
                end
                rgc_pkg::AGC_ARMED: begin
                    if (freeze_now) begin
                        agc_state_q <= rgc_pkg::AGC_FROZEN;
                    end
                end
                rgc_pkg::AGC_FROZEN: begin
                    if (tx_done_i) begin
                        agc_state_q <= rgc_pkg::AGC_ARMED;
                    end
                end
            endcase
        end
    end

    // Pulse count restarts with each new transmission
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pulse_cnt_q <= 4'h0;
        end else if (tx_done_i || agc_state_q != rgc_pkg::AGC_ARMED) begin
            pulse_cnt_q <= 4'h0;
        end else if (agc_run && subcarrier_pulse_i
                     && pulse_cnt_q != 4'hf) begin
            pulse_cnt_q <= pulse_cnt_q + 4'h1;
        end
    end

    // Comparator adjustment first, automatic gain reduction after
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            comp_q <= 3'h0;
            gain_q <= 2'h0;
        end else if (!en_i || !agc_enable_i || tx_done_i) begin
            comp_q <= 3'h0;
            gain_q <= 2'h0;
        end else if (agc_run && agc_hit) begin
            if (comp_q != rgc_pkg::AGC_COMP_STEPS) begin
                comp_q <= comp_q + 3'h1;
            end else if (gain_q != rgc_pkg::AGC_GAIN_STEPS) begin
                gain_q <= gain_q + 2'h1;
            end
        end
    end

    // Regulator decode
    assign vcode = {5'h00, reg_ctrl_q[2:0]};

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            auto_q <= 1'b0;
            peak_off_q <= 1'b0;
            io_low_q <= 1'b0;
            hr_q <= rgc_pkg::HR_MV_400;
            vrf_q <= 8'h00;
            va_q <= 8'h00;
            vx_q <= 8'h00;
        end else begin
            auto_q <= reg_ctrl_q[rgc_pkg::RG_B_AUTO];
            peak_off_q <= reg_ctrl_q[rgc_pkg::RG_B_EXT_AMP];
            io_low_q <= reg_ctrl_q[rgc_pkg::RG_B_IO_LOW];
            // Bit 2 ignored; code 01 has no setting, falls to widest
            unique case (reg_ctrl_q[1:0])
                2'b11: hr_q <= rgc_pkg::HR_MV_250;
                2'b10: hr_q <= rgc_pkg::HR_MV_350;
                default: hr_q <= rgc_pkg::HR_MV_400;
            endcase
            if (reg_ctrl_q[rgc_pkg::RG_B_AUTO]) begin
                // Tracking input: only the digital cap is known here
                vrf_q <= 8'h00;
                va_q <= 8'h00;
                vx_q <= rgc_pkg::V_X_CAP;
            end else if (five_volt_sys_i) begin
                vrf_q <= rgc_pkg::V_RF5_BASE + vcode;
                va_q <= rgc_pkg::V_A5_FIXED;
                vx_q <= rgc_pkg::V_X_CAP;
            end else begin
                vrf_q <= rgc_pkg::V_3V_BASE + vcode;
                va_q <= rgc_pkg::V_3V_BASE + vcode;
                vx_q <= rgc_pkg::V_3V_BASE + vcode;
            end
        end
    end

    assign rdata_o = rdata_q;
    assign rdata_valid_o = rdata_valid_q;
    assign band_o = band_q;
    assign gain_reduce_db_o = gain_db_q;
    assign agc_level_mult_o = mult_q;
    assign comp_adj_step_o = comp_q;
    assign agc_gain_step_o = gain_q;
    assign agc_frozen_o = agc_state_q == rgc_pkg::AGC_FROZEN;
    assign auto_reg_o = auto_q;
    assign headroom_mv_o = hr_q;
    assign vdd_rf_dv_o = vrf_q;
    assign vdd_a_dv_o = va_q;
    assign vdd_x_dv_o = vx_q;
    assign peak_det_off_o = peak_off_q;
    assign mod_pin_output_o = peak_off_q;
    assign io_low_drive_o = io_low_q;

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    AST_RX_PRESET: assert property (
        wr_iso |=> rx_set_q == rgc_pkg::RX_SET_RST)
        else $error("rx register not preset by protocol write");
    AST_EN_LOW: assert property (
        !en_i |=> reg_ctrl_q == rgc_pkg::REG_CTRL_RST
            && rx_set_q == rgc_pkg::RX_SET_RST)
        else $error("registers not preset while enable low");
    AST_DEF_BAND: assert property (
        rx_set_q[7:4] == 4'h0 |=> band_q.band_240k_1400k_default)
        else $error("default band not selected");
    AST_HBT: assert property (
        rx_set_q[rgc_pkg::RX_B_HBT] |=> band_q.band_100k_1500k_hbt
            && gain_db_q >= rgc_pkg::GR_DB_HBT)
        else $error("high bit rate band or reduction missing");
    AST_GAIN_15: assert property (
        rx_set_q[4:2] == 3'b011 |=> gain_db_q == 6'h0f)
        else $error("gain reduction code 11 not 15 dB");
    AST_THRESH: assert property (
        rx_set_q[rgc_pkg::RX_B_AGC_THR] |=> mult_q == rgc_pkg::AGC_MULT_LOW)
        else $error("agc threshold not lowered");
    AST_AGC_OFF: assert property (
        !agc_enable_i |=> comp_q == 3'h0 && gain_q == 2'h0
            && agc_state_q == rgc_pkg::AGC_OFF)
        else $error("agc active while disabled");
    AST_STEP_ORDER: assert property (
        gain_q != 2'h0 |-> comp_q == rgc_pkg::AGC_COMP_STEPS)
        else $error("gain step before comparator steps done");
    AST_ARM: assert property (
        en_i && agc_enable_i && tx_done_i
            |=> agc_state_q == rgc_pkg::AGC_ARMED)
        else $error("agc not armed after transmission");
    AST_FROZEN: assert property (
        agc_state_q == rgc_pkg::AGC_FROZEN && !tx_done_i
            && agc_enable_i && en_i |=> $stable(comp_q) && $stable(gain_q))
        else $error("agc moved while frozen");
    AST_UNUSED: assert property (
        reg_ctrl_q[4:3] == 2'b00)
        else $error("unused regulator bits set");
    AST_MAN5: assert property (
        reg_ctrl_q[7] == 1'b0 && reg_ctrl_q[2:0] == 3'h7 && five_volt_sys_i
            |=> vrf_q == 8'h32 && va_q == 8'h23 && vx_q == 8'h22)
        else $error("manual 5V code 111 wrong supplies");
    AST_AUTO_HR: assert property (
        reg_ctrl_q[7] && reg_ctrl_q[1:0] == 2'b10 |=> hr_q == 9'h15e)
        else $error("auto headroom 10 not 350 mV");

endmodule

`default_nettype wire

// File: verification/rgc_host_model.sv
// Host model: issues register writes and reads into the control bank.
// Assumes the core clock; requests change at falling edges only.
`timescale 1ns/1ns
`default_nettype none

module rgc_host_model (
    input wire logic core_clk_i, // Core clock
    input wire logic [7:0] rdata_i, // Read data
    input wire logic rdata_valid_i, // Read data valid
    output var rgc_pkg::rgc_host_req_s host_req_o // Host access
);
    logic [12:0] last_acc;

    // Idle bus shows the inverted last access, so stale values never match
    task automatic drive(input logic [1:0] op, input logic [12:0] acc);
        @(negedge core_clk_i);
        host_req_o = {op, acc};
        last_acc = acc;
        @(negedge core_clk_i);
        host_req_o = {2'b00, ~last_acc};
    endtask

    task automatic write(input logic [4:0] addr, input logic [7:0] data);
        drive(2'b10, {addr, data});
    endtask

    // Valid stands one cycle only: sample at the falling edge in the middle of it
    task automatic read(input logic [4:0] addr, output logic vld,
                        output logic [7:0] data);
        drive(2'b01, {addr, ~last_acc[7:0]});
        vld = rdata_valid_i;
        data = rdata_i;
    endtask

    // New standard first, then the host's own filter correction
    task automatic select_standard(input logic [7:0] iso,
                                   input logic [7:0] rx);
        write(rgc_pkg::ADDR_ISO_CTRL, iso);
        write(rgc_pkg::ADDR_RX_SET, rx);
    endtask

    // A low I/O supply needs the low-voltage drive bit
    task automatic set_regulator(input logic [7:0] val, input logic low_io);
        if (low_io) val[5] = 1'b1;
        write(rgc_pkg::ADDR_REG_CTRL, val);
    endtask

    initial begin
        last_acc = 13'h0000;
        host_req_o = 15'h0000;
    end
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the receive gain and regulator control bank.
// Assumes the host model drives all register traffic at falling edges.
`timescale 1ns/1ns
`default_nettype none

module testbench;
    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] wdata;
        logic fv;
        logic [39:0] exp;
    } rgc_tb_row_s;

    logic core_clk_i, rst_i, en_i, five_volt_sys_i, agc_enable_i;
    logic tx_done_i, rx_active_i, subcarrier_pulse_i;
    logic lvl_over_3x_i, lvl_over_5x_i;
    rgc_pkg::rgc_host_req_s host_req;
    rgc_pkg::rgc_band_s band_o;
    logic [7:0] rdata_o, vdd_rf_dv_o, vdd_a_dv_o, vdd_x_dv_o;
    logic [5:0] gain_reduce_db_o;
    logic [2:0] agc_level_mult_o, comp_adj_step_o;
    logic [1:0] agc_gain_step_o;
    logic [8:0] headroom_mv_o;
    logic rdata_valid_o, agc_frozen_o, auto_reg_o, peak_det_off_o;
    logic mod_pin_output_o, io_low_drive_o;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    rgc_tb_row_s rows[$];

    rgc_ctrl u_rgc_ctrl (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .en_i(en_i), .host_req_i(host_req), .rdata_o(rdata_o),
        .rdata_valid_o(rdata_valid_o), .five_volt_sys_i(five_volt_sys_i),
        .agc_enable_i(agc_enable_i), .tx_done_i(tx_done_i),
        .rx_active_i(rx_active_i), .subcarrier_pulse_i(subcarrier_pulse_i),
        .lvl_over_3x_i(lvl_over_3x_i), .lvl_over_5x_i(lvl_over_5x_i),
        .band_o(band_o), .gain_reduce_db_o(gain_reduce_db_o),
        .agc_level_mult_o(agc_level_mult_o),
        .comp_adj_step_o(comp_adj_step_o),
        .agc_gain_step_o(agc_gain_step_o), .agc_frozen_o(agc_frozen_o),
        .auto_reg_o(auto_reg_o), .headroom_mv_o(headroom_mv_o),
        .vdd_rf_dv_o(vdd_rf_dv_o), .vdd_a_dv_o(vdd_a_dv_o),
        .vdd_x_dv_o(vdd_x_dv_o), .peak_det_off_o(peak_det_off_o),
        .mod_pin_output_o(mod_pin_output_o),
        .io_low_drive_o(io_low_drive_o));

    rgc_host_model u_rgc_host_model (.core_clk_i(core_clk_i),
        .rdata_i(rdata_o), .rdata_valid_i(rdata_valid_o),
        .host_req_o(host_req));

    task automatic final_report();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [39:0] exp,
                         input logic [39:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd_check(input logic [4:0] addr, input logic [7:0] exp);
        logic vld;
        logic [7:0] d;
        u_rgc_host_model.read(addr, vld, d);
        check("read", {31'h0, 1'b1, exp}, {31'h0, vld, d});
    endtask

    task automatic agc_check(input logic [2:0] c, input logic [1:0] g,
                             input logic f);
        check("agc", {34'h0, c, g, f},
              {34'h0, comp_adj_step_o, agc_gain_step_o, agc_frozen_o});
    endtask

    task automatic arm();
        @(negedge core_clk_i);
        tx_done_i = 1'b1;
        @(negedge core_clk_i);
        tx_done_i = 1'b0;
    endtask

    task automatic pulses(input int n);
        repeat (n) begin
            @(negedge core_clk_i);
            subcarrier_pulse_i = 1'b1;
            @(negedge core_clk_i);
            subcarrier_pulse_i = 1'b0;
        end
    endtask

    function automatic logic [39:0] observe(input logic [4:0] addr);
        if (addr == rgc_pkg::ADDR_RX_SET) begin
            return {26'h0, band_o, gain_reduce_db_o, agc_level_mult_o};
        end
        return {3'h0, auto_reg_o, headroom_mv_o, vdd_rf_dv_o, vdd_a_dv_o,
                vdd_x_dv_o, peak_det_off_o, mod_pin_output_o,
                io_low_drive_o};
    endfunction

    function automatic rgc_tb_row_s rx(input logic [7:0] w,
        input logic [4:0] b, input logic [5:0] g, input logic [2:0] m);
        return '{rgc_pkg::ADDR_RX_SET, w, 1'b0, {26'h0, b, g, m}};
    endfunction

    // Automatic mode: rf and analog report 0, digital at its cap
    function automatic rgc_tb_row_s rg(input logic [7:0] w, input logic fv,
        input logic [8:0] hr, input logic pk, input logic io);
        return '{rgc_pkg::ADDR_REG_CTRL, w, fv,
                 {4'h1, hr, 16'h0000, 8'h22, pk, pk, io}};
    endfunction

    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end

    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            final_report();
        end
    end

    initial begin
        logic [7:0] mask;
        {rst_i, en_i, five_volt_sys_i, agc_enable_i} = 4'b1100;
        {tx_done_i, rx_active_i, subcarrier_pulse_i} = 3'b000;
        {lvl_over_3x_i, lvl_over_5x_i} = 2'b00;
        rows = '{rx(8'h00, 5'h01, 6'h00, 3'h5), rx(8'h80, 5'h10, 6'h00, 3'h5),
                 rx(8'h40, 5'h08, 6'h00, 3'h5), rx(8'h20, 5'h04, 6'h00, 3'h5),
                 rx(8'h10, 5'h02, 6'h12, 3'h5), rx(8'h04, 5'h01, 6'h05, 3'h5),
                 rx(8'h08, 5'h01, 6'h0a, 3'h5), rx(8'h0e, 5'h01, 6'h0f, 3'h3),
                 rx(8'h1c, 5'h02, 6'h21, 3'h5),
                 rg(8'h87, 1'b1, 9'h0fa, 1'b0, 1'b0),
                 rg(8'he2, 1'b0, 9'h15e, 1'b1, 1'b1),
                 rg(8'h9c, 1'b1, 9'h190, 1'b0, 1'b0),
                 rg(8'h81, 1'b0, 9'h190, 1'b0, 1'b0)};
        repeat (16) @(negedge core_clk_i);
        rst_i = 1'b0;
        foreach (rows[i]) begin
            five_volt_sys_i = rows[i].fv;
            u_rgc_host_model.write(rows[i].addr, rows[i].wdata);
            repeat (2) @(negedge core_clk_i);
            check("decode", rows[i].exp, observe(rows[i].addr)
                );
            mask = (rows[i].addr == rgc_pkg::ADDR_REG_CTRL) ? 8'he7 : 8'hff;
            rd_check(rows[i].addr, rows[i].wdata & mask);
        end
        // Manual supplies for every code, both system voltages
        for (int s = 0; s < 2; s++) begin
            for (int c = 0; c < 8; c++) begin
                five_volt_sys_i = s[0];
                u_rgc_host_model.write(rgc_pkg::ADDR_REG_CTRL, {5'h00, c[2:0]});
                repeat (2) @(negedge core_clk_i);
                check("manual", s ? {16'h0, 8'h2b + c[7:0], 16'h2322}
                      : {16'h0, {3{8'h1b + c[7:0]}}},
                      {15'h0, auto_reg_o, vdd_rf_dv_o, vdd_a_dv_o,
                       vdd_x_dv_o});
            end
        end
        rd_check(5'h05, 8'h00);
        u_rgc_host_model.write(rgc_pkg::ADDR_RX_SET, 8'hff);
        u_rgc_host_model.write(rgc_pkg::ADDR_ISO_CTRL, 8'h02);
        rd_check(rgc_pkg::ADDR_RX_SET, 8'h40);
        u_rgc_host_model.select_standard(8'h03, 8'h24);
        rd_check(rgc_pkg::ADDR_RX_SET, 8'h24);
        // AGC: disabled, below threshold, full run, freeze, unlimited
        u_rgc_host_model.write(rgc_pkg::ADDR_RX_SET, 8'h40);
        {rx_active_i, lvl_over_3x_i, lvl_over_5x_i} = 3'b111;
        arm();
        repeat (6) @(negedge core_clk_i);
        agc_check(3'h0, 2'h0, 1'b0);
        agc_enable_i = 1'b1;
        lvl_over_5x_i = 1'b0;
        arm();
        repeat (4) @(negedge core_clk_i);
        agc_check(3'h0, 2'h0, 1'b0);
        lvl_over_5x_i = 1'b1;
        arm();
        repeat (4) @(negedge core_clk_i);
        agc_check(3'h4, 2'h0, 1'b0);
        repeat (3) @(negedge core_clk_i);
        agc_check(3'h4, 2'h3, 1'b0);
        repeat (3) @(negedge core_clk_i);
        agc_check(3'h4, 2'h3, 1'b0);
        {lvl_over_3x_i, lvl_over_5x_i} = 2'b00;
        arm();
        pulses(7);
        agc_check(3'h0, 2'h0, 1'b0);
        pulses(1);
        agc_check(3'h0, 2'h0, 1'b1);
        lvl_over_5x_i = 1'b1;
        repeat (3) @(negedge core_clk_i);
        agc_check(3'h0, 2'h0, 1'b1);
        lvl_over_5x_i = 1'b0;
        u_rgc_host_model.write(rgc_pkg::ADDR_RX_SET, 8'h03);
        repeat (2) @(negedge core_clk_i);
        arm();
        pulses(10);
        lvl_over_3x_i = 1'b1;
        repeat (4) @(negedge core_clk_i);
        agc_check(3'h4, 2'h0, 1'b0);
        // Enable low presets both registers and drops a pending write
        u_rgc_host_model.set_regulator(8'h80, 1'b1);
        rd_check(rgc_pkg::ADDR_REG_CTRL, 8'ha0);
        en_i = 1'b0;
        u_rgc_host_model.write(rgc_pkg::ADDR_RX_SET, 8'h12);
        en_i = 1'b1;
        rd_check(rgc_pkg::ADDR_RX_SET, 8'h40);
        rd_check(rgc_pkg::ADDR_REG_CTRL, 8'h87);
        agc_check(3'h0, 2'h0, 1'b0);
        u_rgc_host_model.write(rgc_pkg::ADDR_REG_CTRL, 8'h00);
        @(negedge core_clk_i);
        rst_i = 1'b1;
        @(negedge core_clk_i);
        rst_i = 1'b0;
        rd_check(rgc_pkg::ADDR_RX_SET, 8'h40);
        rd_check(rgc_pkg::ADDR_REG_CTRL, 8'h87);
        check("rst", {26'h0, 5'h08, 6'h00, 3'h5},
              observe(rgc_pkg::ADDR_RX_SET));
        final_report();
    end
endmodule
`default_nettype wire
